// File: msq_core.sv
// Design decisions made here: the APB slave port and the register addresses.
module msq_core #(
  parameter int unsigned TICK_CYCLES = msq_pkg::TICK_CYCLES,
  parameter int unsigned DEPTH       = msq_pkg::DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  sensor,
  output logic [3:0]       motor_fwd,
  output logic [3:0]       motor_rev,
  output logic [3:0]       lamp
);
  import msq_pkg::*;

  localparam int unsigned DW = $clog2(TICK_CYCLES);
  localparam int unsigned PW = $clog2(DEPTH + 1);

  typedef struct packed {
    msq_state_type           st;
    logic [PW-1:0]           pc;       // Command being executed
    logic [PW-1:0]           len;      // Commands held in the store
    logic [PW-1:0]           idx;      // Host pointer into the store
    logic [TS_W-1:0]         tnow;     // Script time in tenths
    logic [3:0]              tsub;     // Steps within the current tenth
    logic [DW-1:0]           div;      // Time base divider
    logic                    tick;
    logic                    armed;
    logic [2:0]              ev;       // Blue, red, green event levels
    logic [3:0]              hold_f;
    logic [3:0]              hold_r;
    logic [3:0]              cont;
    logic [3:0]              dir_rev;  // Last chosen manual direction
    logic [3:0]              scr_f;
    logic [3:0]              scr_r;
    logic [3:0]              out_f;
    logic [3:0]              out_r;
    logic [3:0][2:0]         lmode;
    logic [3:0]              lload;
    logic [3:0]              pwm;
    logic [2:0]              sa;       // Sensor sync, first stage
    logic [2:0]              sb;       // Sensor sync, second stage
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [DEPTH-1:0][31:0]  mem;      // Script store
  } msq_core_type;

  localparam msq_core_type RESET_Q = '{st: ST_IDLE, default: '0};

  msq_core_type q;
  msq_core_type n;
  logic [31:0]  cmd;
  logic [7:0]   ev_src;
  logic         acc;
  logic         wr;
  logic         in_store;

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign motor_fwd = q.out_f;
  assign motor_rev = q.out_r;

  // Lamp effect engines; only the third lamp may flicker
  for (genvar i = 0; i < 4; i++)
  begin : g_lamp
    msq_lamp_fx #(
      .FLICKER_EN (i == 2)
    ) u_fx (
      .core_clk  (core_clk),
      .rst       (rst),
      .tick      (q.tick),
      .pwm_phase (q.pwm),
      .mode      (q.lmode[i]),
      .load      (q.lload[i]),
      .lamp      (lamp[i])
    );
  end

  // All next-state logic
  always_comb
  begin
    n        = q;
    cmd      = (q.pc < PW'(DEPTH)) ? q.mem[q.pc] : 32'h0000_0000;
    ev_src   = {2'b00, q.sb, q.ev};
    acc      = psel & penable & q.pready;
    wr       = acc & pwrite;
    in_store = (q.idx < PW'(DEPTH));
    n.lload  = 4'h0;
    n.tick   = 1'b0;
    n.pwm    = q.pwm + 4'h1;

    // Sensor pins pass two flops before anything reads them
    n.sa = sensor;
    n.sb = q.sa;

    // Shared 10 ms time base
    if (q.div == DW'(TICK_CYCLES - 1))
    begin
      n.div  = '0;
      n.tick = 1'b1;
    end
    else
      n.div = q.div + DW'(1);

    // APB answer is prepared in the setup cycle, one access cycle
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        REG_CTRL:
          n.prdata = {25'h0, q.ev, 3'h0, q.armed};
        REG_STATUS:
          n.prdata = {{(16-PW){1'b0}}, q.len, {(8-PW){1'b0}}, q.pc, 4'h0, q.st};
        REG_MANUAL:
          n.prdata = {16'h0, q.dir_rev, q.cont, q.hold_r, q.hold_f};
        REG_INDEX:
          n.prdata = {{(32-PW){1'b0}}, q.idx};
        REG_DATA:
        begin
          if (in_store)
            n.prdata = q.mem[q.idx];
          else
            n.pslverr = 1'b1;
        end
        REG_LEN:
          n.prdata = {{(32-PW){1'b0}}, q.len};
        REG_TIME:
          n.prdata = {{(32-TS_W){1'b0}}, q.tnow};
        REG_LAMP:
          n.prdata = {20'h0, q.lmode};
        REG_OUT:
          n.prdata = {12'h0, q.lmode, q.out_r, q.out_f};
        default:
          n.pslverr = 1'b1;
      endcase
      // Lengths beyond the store are refused
      if (pwrite && paddr == REG_LEN && pwdata > 32'(DEPTH))
        n.pslverr = 1'b1;
    end

    // Store access moves the pointer on, read or write
    if (acc && paddr == REG_DATA && in_store)
    begin
      n.idx = q.idx + PW'(1);
      if (pwrite)
      begin
        n.mem[q.idx] = pwdata;
        if (q.idx >= q.len)
          n.len = q.idx + PW'(1);
      end
    end

    // Host register writes
    if (wr)
    begin
      unique case (paddr)
        REG_CTRL:
        begin
          n.armed = pwdata[ARM_BIT];
          n.ev    = pwdata[EV_LSB +: 3];
        end
        REG_MANUAL:
        begin
          n.hold_f = pwdata[HF_LSB +: 4];
          n.hold_r = pwdata[HR_LSB +: 4];
          n.cont   = pwdata[CONT_LSB +: 4];
          for (int i = 0; i < 4; i++)
          begin
            // A pressed direction becomes the remembered one
            if (pwdata[HF_LSB + i])
              n.dir_rev[i] = 1'b0;
            else if (pwdata[HR_LSB + i])
              n.dir_rev[i] = 1'b1;
          end
        end
        REG_INDEX:
        begin
          if (pwdata <= 32'(DEPTH))
            n.idx = PW'(pwdata);
        end
        REG_LEN:
        begin
          if (pwdata <= 32'(DEPTH))
            n.len = PW'(pwdata);
        end
        REG_LAMP:
        begin
          for (int i = 0; i < 4; i++)
          begin
            n.lmode[i] = pwdata[3*i +: 3];
            n.lload[i] = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Script time advances while a script is live
    if ((q.st == ST_RUN || q.st == ST_WAIT) && q.tick)
    begin
      if (q.tsub == 4'(TICKS_PER_TENTH - 1))
      begin
        n.tsub = 4'h0;
        if (q.tnow != {TS_W{1'b1}})
          n.tnow = q.tnow + TS_W'(1);
      end
      else
        n.tsub = q.tsub + 4'h1;
    end

    // Sequencer
    unique case (q.st)
      ST_IDLE:
      begin
      end
      ST_RUN:
      begin
        if (q.pc >= q.len)
          n.st = ST_DONE;
        else if (q.tnow >= cmd[TS_LSB +: TS_W])
        begin
          unique case (cmd[OP_LSB +: 2])
            OP_SET:
            begin
              for (int i = 0; i < 4; i++)
              begin
                n.scr_f[i] = (cmd[MOT_LSB + 2*i +: 2] == MC_FWD);
                n.scr_r[i] = (cmd[MOT_LSB + 2*i +: 2] == MC_REV);
              end
              n.lmode[0] = {1'b0, cmd[L1_LSB +: 2]};
              n.lmode[1] = {1'b0, cmd[L2_LSB +: 2]};
              n.lmode[2] = cmd[L3_LSB +: 3];
              n.lmode[3] = {1'b0, cmd[L4_LSB +: 2]};
              n.lload    = 4'hF;
              n.pc       = q.pc + PW'(1);
            end
            OP_WAIT:
              n.st = ST_WAIT;
            OP_RESTART:
            begin
              n.pc   = '0;
              n.tnow = '0;
              n.tsub = 4'h0;
            end
            OP_STOP:
              n.st = ST_DONE;
          endcase
        end
      end
      ST_WAIT:
      begin
        // Resume with the next command once the event shows
        if (ev_src[cmd[WEV_LSB +: 3]])
        begin
          n.pc = q.pc + PW'(1);
          n.st = ST_RUN;
        end
      end
      ST_DONE:
      begin
        // Finished; a new start, a halt or a disarm leaves here
      end
    endcase

    // Host start, taken only while armed
    if (wr && paddr == REG_CTRL && pwdata[START_BIT] && pwdata[ARM_BIT])
    begin
      n.st   = ST_RUN;
      n.pc   = '0;
      n.tnow = '0;
      n.tsub = 4'h0;
    end

    // Halt or disarm beats start; script motor drive drops
    // The arm level of this very write counts, so arm and start may share one write
    if ((wr && paddr == REG_CTRL && (pwdata[HALT_BIT] || !pwdata[ARM_BIT])) || !n.armed)
    begin
      n.st    = ST_IDLE;
      n.scr_f = 4'h0;
      n.scr_r = 4'h0;
    end

    // Motor drive: held buttons, then continuous run, then script
    for (int i = 0; i < 4; i++)
    begin
      if (q.hold_f[i])
      begin
        n.out_f[i] = 1'b1;
        n.out_r[i] = 1'b0;
      end
      else if (q.hold_r[i])
      begin
        n.out_f[i] = 1'b0;
        n.out_r[i] = 1'b1;
      end
      else if (q.cont[i])
      begin
        n.out_f[i] = ~q.dir_rev[i];
        n.out_r[i] = q.dir_rev[i];
      end
      else
      begin
        n.out_f[i] = q.scr_f[i];
        n.out_r[i] = q.scr_r[i];
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= RESET_Q;
    else
      q <= n;
  end
endmodule

// File: msq_core_props.sv
module msq_core_props
#(
  parameter int unsigned TICK_CYCLES = 20,
  parameter int unsigned DEPTH       = 60
)
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  sensor,
  input wire logic [3:0]  motor_fwd,
  input wire logic [3:0]  motor_rev,
  input wire logic [3:0]  lamp
);
  import msq_pkg::*;
  // Word-aligned offsets up to the last register are mapped
  logic mapped;
  assign mapped = (paddr <= REG_OUT) && (paddr[1:0] == 2'h0);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Bus steps: setup, then the single answered access cycle
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  no_idle_ready_a: assert property (!psel |=> !pready)
    else $error("pready without request");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  unmapped_error_a: assert property ((access_s and (!mapped))
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  ctrl_no_error_a: assert property ((access_s and (paddr == REG_CTRL)) |-> !pslverr)
    else $error("control access refused");
  motor_exclusive_a: assert property ((motor_fwd & motor_rev) == 4'h0)
    else $error("motor driven both ways");
  hold_fwd_drive_a: assert property ((access_s and (pwrite && paddr == REG_MANUAL && pwdata[0]))
    |-> ##[1:3] motor_fwd[0])
    else $error("held forward not driven");
  reset_quiet_a: assert property ($fell(rst) |-> {motor_fwd, motor_rev, lamp} == 12'h000)
    else $error("outputs active after reset");
endmodule
bind msq_core msq_core_props #(.TICK_CYCLES(TICK_CYCLES), .DEPTH(DEPTH)) msq_core_props_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sensor(sensor), .motor_fwd(motor_fwd), .motor_rev(motor_rev), .lamp(lamp));

// File: msq_lamp_fx.sv
module msq_lamp_fx #(
  parameter bit FLICKER_EN = 1'b0
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic [3:0] pwm_phase,
  input  wire logic [2:0] mode,
  input  wire logic       load,
  output logic            lamp
);
  import msq_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;       // Steps within the current phase
    logic [8:0] left;      // Burst steps remaining
    logic [7:0] lfsr;      // Pseudo-random source
    logic [3:0] inten;     // Flicker intensity
    logic [4:0] flen;      // Flicker flash steps remaining
    logic       ph;        // Cycle phase
    logic       lamp;
  } msq_fx_type;

  msq_fx_type q;
  msq_fx_type n;

  assign lamp = q.lamp;

  // One mode at a time; a fresh load restarts the effect
  always_comb
  begin
    n = q;
    if (tick)
    begin
      n.lfsr = {q.lfsr[6:0], ~(q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3])};
    end
    if (load)
    begin
      // Replacing the state drops the counters of the old one; inten and lfsr are kept
      n.cnt  = '0;
      n.ph   = 1'b1;
      n.flen = '0;
      n.left = 9'(BURST_TICKS);
    end
    else if (tick)
    begin
      if (mode == LM_BURST)
      begin
        // Short pulses until the burst window runs out
        n.cnt = (q.cnt == 8'(BURST_PER_TICKS - 1)) ? 8'h00 : q.cnt + 8'h01;
        if (q.left != 9'h000)
          n.left = q.left - 9'h001;
      end
      else if (mode == LM_CYCLE)
      begin
        // Equal halves give a 50 percent duty
        if (q.cnt == 8'(CYCLE_HALF_TICKS - 1))
        begin
          n.cnt = 8'h00;
          n.ph  = ~q.ph;
        end
        else
          n.cnt = q.cnt + 8'h01;
      end
      else if (mode == LM_FLICK)
      begin
        // New random brightness and length when a flash ends
        if (q.flen == 5'h00)
        begin
          n.inten = q.lfsr[3:0];
          n.flen  = {1'b0, q.lfsr[7:4]} + 5'h01;
        end
        else
          n.flen = q.flen - 5'h01;
      end
    end
    // Output decode; codes a lamp lacks read as off
    unique case (mode)
      LM_ON:    n.lamp = 1'b1;
      LM_BURST: n.lamp = (q.left != 9'h000) && (q.cnt < 8'(BURST_ON_TICKS));
      LM_CYCLE: n.lamp = q.ph;
      LM_FLICK: n.lamp = FLICKER_EN && (pwm_phase < q.inten);
      default:  n.lamp = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= n;
  end
endmodule

// File: msq_pkg.sv
package msq_pkg;
  // Core clock rate and the shared time base step
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TENTH_MS        = 100;
  localparam int unsigned TICKS_PER_TENTH = TENTH_MS / TICK_MS;

  // Lamp effect timing, in ms and in time base steps
  localparam int unsigned BURST_MS        = 2500;
  localparam int unsigned BURST_TICKS     = BURST_MS / TICK_MS;
  localparam int unsigned BURST_ON_MS     = 20;
  localparam int unsigned BURST_ON_TICKS  = BURST_ON_MS / TICK_MS;
  localparam int unsigned BURST_PER_MS    = 50;
  localparam int unsigned BURST_PER_TICKS = BURST_PER_MS / TICK_MS;
  localparam int unsigned CYCLE_HALF_MS   = 250;
  localparam int unsigned CYCLE_HALF_TICKS = CYCLE_HALF_MS / TICK_MS;

  // Script store size
  localparam int unsigned DEPTH = 60;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MANUAL = 8'h08;
  localparam logic [7:0] REG_INDEX  = 8'h0C;
  localparam logic [7:0] REG_DATA   = 8'h10;
  localparam logic [7:0] REG_LEN    = 8'h14;
  localparam logic [7:0] REG_TIME   = 8'h18;
  localparam logic [7:0] REG_LAMP   = 8'h1C;
  localparam logic [7:0] REG_OUT    = 8'h20;

  // Field positions
  localparam int unsigned ARM_BIT   = 0;
  localparam int unsigned START_BIT = 1;
  localparam int unsigned HALT_BIT  = 2;
  localparam int unsigned EV_LSB    = 4;
  localparam int unsigned HF_LSB    = 0;
  localparam int unsigned HR_LSB    = 4;
  localparam int unsigned CONT_LSB  = 8;
  localparam int unsigned DIR_LSB   = 12;
  localparam int unsigned PC_LSB    = 8;
  localparam int unsigned LEN_LSB   = 16;
  localparam int unsigned OUTL_LSB  = 8;

  // Command word layout
  localparam int unsigned TS_LSB  = 0;
  localparam int unsigned TS_W    = 13;
  localparam int unsigned OP_LSB  = 13;
  localparam int unsigned MOT_LSB = 15;
  localparam int unsigned WEV_LSB = 15;
  localparam int unsigned L1_LSB  = 23;
  localparam int unsigned L2_LSB  = 25;
  localparam int unsigned L3_LSB  = 27;
  localparam int unsigned L4_LSB  = 30;

  // Encodings
  localparam logic [1:0] OP_SET     = 2'h0;
  localparam logic [1:0] OP_WAIT    = 2'h1;
  localparam logic [1:0] OP_RESTART = 2'h2;
  localparam logic [1:0] OP_STOP    = 2'h3;
  localparam logic [1:0] MC_FWD     = 2'h1;
  localparam logic [1:0] MC_REV     = 2'h2;
  localparam logic [2:0] LM_OFF     = 3'h0;
  localparam logic [2:0] LM_ON      = 3'h1;
  localparam logic [2:0] LM_BURST   = 3'h2;
  localparam logic [2:0] LM_CYCLE   = 3'h3;
  localparam logic [2:0] LM_FLICK   = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN  = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } msq_state_type;
endpackage

// File: msq_sensor_model.sv
module msq_sensor_model
(
  input  wire logic       core_clk,
  input  wire logic [2:0] press,
  output logic      [2:0] sensor = 3'h0
);
  import msq_pkg::*;
  // Pins follow the pressed level one edge later; the core syncs them itself
  always_ff @(posedge core_clk)
    sensor <= press;
endmodule

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msq_pkg::*;
  // Short time base step so the lamp and script timing fits the run
  localparam int SIM_TICK = 20;
  localparam int TENTH    = SIM_TICK * TICKS_PER_TENTH;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [2:0]  press    = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  sensor;
  logic [3:0]  motor_fwd;
  logic [3:0]  motor_rev;
  logic [3:0]  lamp;
  int          checks     = 0;
  int          mismatches = 0;
  msq_core #(.TICK_CYCLES(SIM_TICK), .DEPTH(DEPTH)) msq_core_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor(sensor), .motor_fwd(motor_fwd), .motor_rev(motor_rev), .lamp(lamp));
  msq_sensor_model msq_sensor_model_i (.core_clk(core_clk), .press(press), .sensor(sensor));
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  function automatic logic [31:0] cmd(input logic [12:0] ts, input logic [1:0] op,
                                      input logic [7:0] mot, input logic [8:0] lmp);
    return {lmp, mot, op, ts};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("write error", {31'h0, ee}, {31'h0, e});
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, exp, q);
  endtask
  // Bounded poll of a masked register field
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0, q, e);
      n++;
    end
    while ((q & m) !== exp && n < 400);
    chk("poll", exp, q & m);
  endtask
  task automatic measure(input int b, input int cyc, output int hi, output int ri);
    logic last;
    hi = 0;
    ri = 0;
    last = lamp[b];
    repeat (cyc)
    begin
      @(posedge core_clk);
      hi += int'(lamp[b] === 1'b1);
      ri += int'(lamp[b] === 1'b1 && last !== 1'b1);
      last = lamp[b];
    end
  endtask
  task automatic t_reset();
    rd("status", REG_STATUS, 32'h1);
    rd("time", REG_TIME, 32'h0);
    rd("unmapped", 8'h24, 32'h0);
    wr(8'h24, 32'hFFFF_FFFF, 1'b1);
  endtask
  task automatic t_manual();
    wr(REG_MANUAL, 32'h0000_0001, 1'b0);
    rd("hold fwd", REG_OUT, 32'h1);
    chk("fwd pin", 32'h1, {28'h0, motor_fwd});
    wr(REG_MANUAL, 32'h0000_0010, 1'b0);
    rd("hold rev", REG_OUT, 32'h10);
    wr(REG_MANUAL, 32'h0, 1'b0);
    rd("released", REG_OUT, 32'h0);
    wr(REG_MANUAL, 32'h0000_0100, 1'b0);
    rd("cont dir", REG_MANUAL, 32'h0000_1100);
    rd("cont run", REG_OUT, 32'h10);
    chk("rev pin", 32'h1, {28'h0, motor_rev});
    wr(REG_MANUAL, 32'h0, 1'b0);
    rd("cont stop", REG_OUT, 32'h0);
  endtask
  task automatic t_lamp();
    int hi;
    int ri;
    wr(REG_LAMP, 32'h0000_0841, 1'b0);
    rd("lamp reg", REG_LAMP, 32'h0000_0841);
    chk("lamp pins", 32'h5, {28'h0, lamp});
    wr(REG_LAMP, 32'h0000_0003, 1'b0);
    measure(0, 2 * CYCLE_HALF_TICKS * SIM_TICK, hi, ri);
    measure(0, 2 * CYCLE_HALF_TICKS * SIM_TICK, hi, ri);
    chk("cycle duty", 32'(CYCLE_HALF_TICKS * SIM_TICK), 32'(hi));
    wr(REG_LAMP, 32'h0, 1'b0);
    rd("lamp off", REG_OUT, 32'h0);
    wr(REG_LAMP, 32'h0000_0002, 1'b0);
    measure(0, (BURST_TICKS + 4 * BURST_PER_TICKS) * SIM_TICK, hi, ri);
    chk("burst pulses", 32'h1, {31'h0, ri >= 45 && ri <= 51});
    chk("burst end", 32'h0, {31'h0, lamp[0]});
    wr(REG_LAMP, 32'h0000_0100, 1'b0);
    measure(2, 4000, hi, ri);
    chk("flicker", 32'h1, {31'h0, ri > 2 && hi < 4000});
    wr(REG_LAMP, 32'h0, 1'b0);
  endtask
  // Every wait event in turn: store, read back, refuse unarmed start, run
  task automatic t_script();
    logic [31:0] prog [4];
    for (int k = 0; k < 6; k++)
    begin
      prog = '{cmd(0, OP_SET, 8'h09, 9'h0), cmd(0, OP_WAIT, 8'(k), 9'h0),
               cmd(0, OP_SET, 8'h60, 9'h1), cmd(0, OP_STOP, 8'h0, 9'h0)};
      wr(REG_INDEX, 32'h0, 1'b0);
      foreach (prog[i]) wr(REG_DATA, prog[i], 1'b0);
      rd("len", REG_LEN, 32'h4);
      wr(REG_INDEX, 32'h0, 1'b0);
      foreach (prog[i]) rd("retrieve", REG_DATA, prog[i]);
      wr(REG_CTRL, 32'h0, 1'b0);
      wr(REG_CTRL, 32'h0000_0002, 1'b0);
      // Disarm leaves the program counter where the last run stopped
      rd("unarmed", REG_STATUS, (k == 0) ? 32'h0004_0001 : 32'h0004_0301);
      wr(REG_CTRL, 32'h0000_0003, 1'b0);
      poll(REG_STATUS, 32'hF, 32'h4);
      chk("set fwd", 32'h1, {28'h0, motor_fwd});
      chk("set rev", 32'h2, {28'h0, motor_rev});
      if (k < 3)
        wr(REG_CTRL, 32'(1 | (1 << (4 + k))), 1'b0);
      else
        press <= 3'(1 << (k - 3));
      poll(REG_STATUS, 32'hF, 32'h8);
      chk("next fwd", 32'h8, {28'h0, motor_fwd});
      chk("next rev", 32'h4, {28'h0, motor_rev});
      chk("next lamp", 32'h1, {28'h0, lamp});
      poll(REG_STATUS, 32'hF, 32'h8);
      press <= 3'h0;
    end
  endtask
  task automatic t_timing();
    wr(REG_INDEX, 32'h0, 1'b0);
    wr(REG_DATA, cmd(0, OP_SET, 8'h01, 9'h0), 1'b0);
    wr(REG_DATA, cmd(1, OP_SET, 8'h02, 9'h0), 1'b0);
    wr(REG_DATA, cmd(2, OP_RESTART, 8'h0, 9'h0), 1'b0);
    wr(REG_LEN, 32'h3, 1'b0);
    wr(REG_CTRL, 32'h0000_0003, 1'b0);
    repeat (TENTH / 2) @(posedge core_clk);
    chk("before stamp", 32'h1, {28'h0, motor_fwd});
    poll(REG_OUT, 32'hFF, 32'h10);
    poll(REG_OUT, 32'hFF, 32'h01);
    wr(REG_CTRL, 32'h0000_0005, 1'b0);
    poll(REG_STATUS, 32'hF, 32'h1);
    chk("halt motors", 32'h0, {24'h0, motor_rev, motor_fwd});
  endtask
  task automatic t_capacity();
    wr(REG_INDEX, 32'h3B, 1'b0);
    wr(REG_DATA, 32'h0000_6000, 1'b0);
    wr(REG_DATA, 32'h0000_6000, 1'b1);
    rd("full len", REG_LEN, 32'h3C);
    rd("full index", REG_INDEX, 32'h3C);
    wr(REG_LEN, 32'h3D, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_manual();
    t_lamp();
    t_script();
    t_timing();
    t_capacity();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
endmodule
